// >>> verilog/usdb_consts.vh
// Purpose: Shared constants for the UART shadow data buffer.
// Assumes: 32-bit byte addressed register port, one word per register.
// Notes:   Offsets are full byte addresses.
`ifndef USDB_CONSTS_VH
`define USDB_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define USDB_ADDR_CTRL      32'h50001008
`define USDB_ADDR_LSR       32'h50001014
`define USDB_ADDR_ISTAT     32'h50001018
`define USDB_ADDR_IMASK     32'h5000101C
`define USDB_ADDR_SH_FIRST  32'h50001030
`define USDB_ADDR_SH_9      32'h50001054
`define USDB_ADDR_SH_10     32'h50001058
`define USDB_ADDR_SH_LAST   32'h5000106C

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define USDB_CTRL_FIFO_EN   0
`define USDB_CTRL_IR_MODE   1
`define USDB_LSR_DR         0
`define USDB_LSR_OE         1
`define USDB_LSR_TX_HOLDING_EMPTY_FLAG       5
`define USDB_LSR_TEMT       6
`define USDB_INT_RX         0
`define USDB_INT_OE         1
`define USDB_INT_TX_HOLDING_EMPTY_FLAG       2
`define USDB_SH_DATA_W      8
`define USDB_SH_REG_W       16

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define USDB_CTRL_RST       2'h0
`define USDB_IMASK_RST      3'h0
`define USDB_ISTAT_RST      3'h0
`define USDB_SH_RST         16'h0000

////////////////////////////////////////////////////////////////////////////////
// Sizes and timing counts
`define USDB_FIFO_AW        4
`define USDB_BAUD_DIV       16'h0010
`define USDB_IR_PULSE_NUM   3
`define USDB_IR_PULSE_DEN   16

`endif

// >>> verilog/usdb_fifo.v
// Purpose: Character FIFO with registered head output for the shadow buffer.
// Assumes: Single clock; pop is only honoured while not empty.
// Notes:   With fifo_en low it holds one entry and a push onto it overwrites.
module usdb_fifo #(
  parameter W  = 8,
  parameter AW = 4
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // Control
  input  wire          flush,
  input  wire          fifo_en,
  // Fill side
  input  wire          push,
  input  wire [W-1:0]  wdata,
  output wire          drop,
  // Drain side
  input  wire          pop,
  output reg  [W-1:0]  rdata_r,
  output reg  [AW:0]   cnt_r
);

  localparam [AW:0] FULL = {1'b1, {AW{1'b0}}};

  reg  [W-1:0]  mem [0:(1<<AW)-1];
  reg  [AW-1:0] head_r;
  reg  [AW-1:0] tail_r;
  wire          do_pop;
  wire          room;
  wire          do_push;
  wire          ovw;
  wire          wen;
  wire [AW-1:0] waddr;
  wire [AW-1:0] head_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Room: a full FIFO or an occupied single holding slot has none unless a pop is taken in the same cycle
  assign do_pop   = pop && (cnt_r != {(AW+1){1'b0}});
  assign room     = do_pop || (fifo_en ? (cnt_r != FULL) : (cnt_r == {(AW+1){1'b0}}));
  assign do_push  = push && room;
  assign ovw      = push && !room && !fifo_en;
  assign drop     = push && !room;
  assign wen      = do_push || ovw;
  assign waddr    = do_push ? tail_r : head_r;
  assign head_nxt = flush ? {AW{1'b0}} : head_r + {{(AW-1){1'b0}}, do_pop};

  // Storage, no reset on the array
  always @(posedge clk) begin
    if (wen) begin
      mem[waddr] <= wdata;
    end
  end

  // Head word registered; bypass so a write to the new head shows at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= {W{1'b0}};
    end else if (wen && (waddr == head_nxt)) begin
      rdata_r <= wdata;
    end else if (do_pop) begin
      // Only a pop reloads the head word, though a flush also moves the head; holding avoids loading never written words
      rdata_r <= mem[head_nxt];
    end
  end

  // Pointers and fill count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_r <= {AW{1'b0}};
      tail_r <= {AW{1'b0}};
      cnt_r  <= {(AW+1){1'b0}};
    end else if (flush) begin
      head_r <= {AW{1'b0}};
      tail_r <= {AW{1'b0}};
      cnt_r  <= {(AW+1){1'b0}};
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_r + {{(AW-1){1'b0}}, do_push};
      cnt_r  <= cnt_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end

endmodule

// >>> verilog/usdb_core.v
// Purpose: UART data path reached through sixteen shadow data locations.
// Assumes: ref_clk 10 MHz; pins sin and sir_in are asynchronous.
// Notes:   Bit time is BAUD_DIV clocks; 8 data bits, no parity, one stop.
// Summary of operation
// [RL1] Each of sixteen word locations reads the receive buffer and writes the transmit holding.
// [RL2] A read returns in bits 7:0 the byte taken from sin, or from sir_in in infrared mode.
// [RL3] Read data mean something only while the data ready flag is set.
// [RL4] Without FIFOs an unread byte is overwritten by the next and an overrun is flagged.
// [RL5] With FIFOs a read returns the head of the receive FIFO.
// [RL6] A full receive FIFO keeps its contents, drops the new byte and flags an overrun.
// [RL7] Written data leave on sout, or on the active low sir_out_n in infrared mode.
// [RL8] Software writes only while the transmit holding empty flag is set.
// [RL9] Without FIFOs one write clears the transmit holding empty flag.
// [RL10] Without FIFOs a further write before that flag sets replaces the held byte.
// [RL11] With FIFOs writes are taken until the transmit FIFO of 2**FIFO_AW entries is full.
// [RL12] A write to a full transmit FIFO is lost and the FIFO is unchanged.
// [RL13] Bits above 7 of a shadow location read zero and ignore writes.
`include "usdb_consts.vh"
module usdb_core #(
  parameter        FIFO_AW  = `USDB_FIFO_AW,
  parameter [15:0] BAUD_DIV = `USDB_BAUD_DIV
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // Register port
  input  wire [31:0] addr,
  input  wire [31:0] wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [31:0] rdata_r,
  // Serial pins
  input  wire        sin,
  input  wire        sir_in,
  output wire        sout,
  output wire        sir_out_n,
  // Interrupt
  output wire        irq
);

  localparam [1:0]  S_IDLE  = 2'h0;
  localparam [1:0]  S_START = 2'h1;
  localparam [1:0]  S_DATA  = 2'h2;
  localparam [1:0]  S_STOP  = 2'h3;
  localparam [15:0] DIV_M1  = BAUD_DIV - 16'h0001;
  localparam [15:0] HALF    = BAUD_DIV >> 1;
  localparam [31:0] IRP_FULL = (BAUD_DIV * `USDB_IR_PULSE_NUM) / `USDB_IR_PULSE_DEN;
  localparam [15:0] IRP_RAW = IRP_FULL[15:0];
  localparam [15:0] IR_PULSE = (IRP_RAW == 16'h0000) ? 16'h0001 : IRP_RAW;

  reg  [1:0]        rst_sync_r;
  wire              rst_n;
  reg  [1:0]        sin_sync_r;
  reg  [1:0]        sir_sync_r;
  wire              sin_s;
  wire              sir_s;
  reg  [1:0]        ctrl_r;
  reg  [2:0]        imask_r;
  reg  [2:0]        istat_r;
  reg               oe_r;
  reg               tx_holding_empty_flag_d_r;
  wire              fifo_en;
  wire              ir_mode;
  wire              sh_hit;
  wire              ctrl_wr;
  wire              flush;
  wire              dr;
  wire              tx_holding_empty_flag;
  wire              temt;
  wire [2:0]        int_evt;
  reg  [31:0]       rd_mux;
  wire [7:0]        rx_q;
  wire [7:0]        tx_q;
  wire [FIFO_AW:0]  rx_cnt;
  wire [FIFO_AW:0]  tx_cnt;
  wire              rx_drop;
  wire              tx_pop;
  reg  [1:0]        tx_st_r;
  reg  [15:0]       tx_div_r;
  reg  [2:0]        tx_bit_r;
  reg  [7:0]        tx_sh_r;
  reg               sout_r;
  reg               sir_out_n_r;
  wire              tx_tick;
  reg  [1:0]        rx_st_r;
  reg  [15:0]       rx_div_r;
  reg  [2:0]        rx_bit_r;
  reg  [7:0]        rx_sh_r;
  reg               rx_done_r;
  reg               ir_seen_r;
  wire              rx_low;
  wire              rx_bitv;
  wire              rx_sample;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Two flops on each serial input before use
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sin_sync_r <= 2'h3;
      sir_sync_r <= 2'h0;
    end else begin
      sin_sync_r <= {sin_sync_r[0], sin};
      sir_sync_r <= {sir_sync_r[0], sir_in};
    end
  end
  assign sin_s = sin_sync_r[1];
  assign sir_s = sir_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign sh_hit  = (addr >= `USDB_ADDR_SH_FIRST) && (addr <= `USDB_ADDR_SH_LAST) &&
                   (addr[1:0] == 2'h0); // [RL1]
  assign ctrl_wr = wr_stb && (addr == `USDB_ADDR_CTRL);
  assign fifo_en = ctrl_r[`USDB_CTRL_FIFO_EN];
  assign ir_mode = ctrl_r[`USDB_CTRL_IR_MODE];
  // Changing the FIFO mode empties both FIFOs
  assign flush   = ctrl_wr && (wdata[`USDB_CTRL_FIFO_EN] != fifo_en);

  // Control and mask registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= `USDB_CTRL_RST;
      imask_r <= `USDB_IMASK_RST;
    end else if (wr_stb) begin
      if (addr == `USDB_ADDR_CTRL) begin
        ctrl_r <= wdata[1:0];
      end
      if (addr == `USDB_ADDR_IMASK) begin
        imask_r <= wdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive and transmit FIFOs; with FIFOs off each holds a single byte
  usdb_fifo #(
    .W  (`USDB_SH_DATA_W),
    .AW (FIFO_AW)
  ) u_rx_fifo (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .flush   (flush),
    .fifo_en (fifo_en),
    .push    (rx_done_r),
    .wdata   (rx_sh_r),
    .drop    (rx_drop),
    .pop     (rd_stb && sh_hit),
    .rdata_r (rx_q),
    .cnt_r   (rx_cnt)
  ); // [RL4] [RL5] [RL6]

  usdb_fifo #(
    .W  (`USDB_SH_DATA_W),
    .AW (FIFO_AW)
  ) u_tx_fifo (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .flush   (flush),
    .fifo_en (fifo_en),
    .push    (wr_stb && sh_hit),
    .wdata   (wdata[7:0]),
    .drop    (),
    .pop     (tx_pop),
    .rdata_r (tx_q),
    .cnt_r   (tx_cnt)
  ); // [RL10] [RL11] [RL12]

  ////////////////////////////////////////////////////////////////////////////
  // Line status
  assign dr   = (rx_cnt != {(FIFO_AW+1){1'b0}}); // [RL3]
  assign tx_holding_empty_flag = (tx_cnt == {(FIFO_AW+1){1'b0}}); // [RL9]
  assign temt = tx_holding_empty_flag && (tx_st_r == S_IDLE);

  // Overrun flag, cleared by a status read; a new overrun wins
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_r <= 1'b0;
    end else if (rx_drop) begin
      oe_r <= 1'b1; // [RL4] [RL6]
    end else if (rd_stb && (addr == `USDB_ADDR_LSR)) begin
      oe_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: byte arrived, overrun, holding became empty
  assign int_evt = {tx_holding_empty_flag && !tx_holding_empty_flag_d_r, rx_drop, rx_done_r};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_r  <= `USDB_ISTAT_RST;
      tx_holding_empty_flag_d_r <= 1'b1;
    end else begin
      tx_holding_empty_flag_d_r <= tx_holding_empty_flag;
      if (rd_stb && (addr == `USDB_ADDR_ISTAT)) begin
        istat_r <= int_evt;
      end else begin
        istat_r <= istat_r | int_evt;
      end
    end
  end
  assign irq = |(istat_r & imask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read data select
  always @* begin
    rd_mux = 32'h00000000;
    if (sh_hit) begin
      rd_mux[7:0] = rx_q; // [RL2] [RL5] [RL13]
    end else begin
      case (addr)
        `USDB_ADDR_CTRL: begin
          rd_mux[1:0] = ctrl_r;
        end
        `USDB_ADDR_LSR: begin
          rd_mux[`USDB_LSR_DR]   = dr;
          rd_mux[`USDB_LSR_OE]   = oe_r;
          rd_mux[`USDB_LSR_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag;
          rd_mux[`USDB_LSR_TEMT] = temt;
        end
        `USDB_ADDR_ISTAT: begin
          rd_mux[2:0] = istat_r;
        end
        `USDB_ADDR_IMASK: begin
          rd_mux[2:0] = imask_r;
        end
        default: begin
          rd_mux = 32'h00000000;
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (rd_stb) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: takes the head byte when idle and a byte is waiting
  assign tx_pop  = (tx_st_r == S_IDLE) && !tx_holding_empty_flag;
  assign tx_tick = (tx_div_r == DIV_M1);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r  <= S_IDLE;
      tx_div_r <= 16'h0000;
      tx_bit_r <= 3'h0;
      tx_sh_r  <= 8'h00;
      sout_r   <= 1'b1;
    end else begin
      tx_div_r <= (tx_tick || tx_st_r == S_IDLE) ? 16'h0000 : tx_div_r + 16'h0001;
      case (tx_st_r)
        S_IDLE: begin
          sout_r <= 1'b1;
          if (tx_pop) begin
            tx_sh_r <= tx_q;
            sout_r  <= 1'b0;
            tx_st_r <= S_START;
          end
        end
        S_START: begin
          if (tx_tick) begin
            tx_bit_r <= 3'h0;
            sout_r   <= tx_sh_r[0];
            tx_st_r  <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_tick) begin
            tx_sh_r <= tx_sh_r >> 1;
            if (tx_bit_r == 3'h7) begin
              sout_r  <= 1'b1;
              tx_st_r <= S_STOP;
            end else begin
              tx_bit_r <= tx_bit_r + 3'h1;
              sout_r   <= tx_sh_r[1];
            end
          end
        end
        S_STOP: begin
          if (tx_tick) begin
            tx_st_r <= S_IDLE;
          end
        end
        default: begin
          tx_st_r <= S_IDLE;
        end
      endcase
    end
  end

  // Infrared output: short low pulse at the start of each zero bit
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sir_out_n_r <= 1'b1;
    end else begin
      sir_out_n_r <= !(ir_mode && !sout_r && (tx_st_r != S_IDLE) &&
                       (tx_div_r < IR_PULSE)); // [RL7]
    end
  end

  // Normal output parks high while infrared mode is on
  assign sout      = sout_r | ir_mode; // [RL7]
  assign sir_out_n = sir_out_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver line: a pulse on sir_in marks a zero bit in infrared mode
  assign rx_low    = ir_mode ? sir_s : !sin_s; // [RL2]
  assign rx_bitv   = ir_mode ? !(ir_seen_r || sir_s) : sin_s;
  assign rx_sample = ((rx_st_r == S_START) && (rx_div_r == HALF)) ||
                     ((rx_st_r == S_DATA || rx_st_r == S_STOP) && (rx_div_r == DIV_M1));

  // Infrared pulse catcher, emptied at each sample point
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_seen_r <= 1'b0;
    end else if (rx_sample || rx_st_r == S_IDLE) begin
      ir_seen_r <= 1'b0;
    end else if (sir_s) begin
      ir_seen_r <= 1'b1;
    end
  end

  // Receive state machine
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r   <= S_IDLE;
      rx_div_r  <= 16'h0000;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      rx_div_r  <= (rx_sample || rx_st_r == S_IDLE) ? 16'h0000 : rx_div_r + 16'h0001;
      case (rx_st_r)
        S_IDLE: begin
          if (rx_low) begin
            rx_st_r <= S_START;
          end
        end
        S_START: begin
          if (rx_sample) begin
            rx_bit_r <= 3'h0;
            rx_st_r  <= rx_bitv ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_sample) begin
            rx_sh_r  <= {rx_bitv, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == 3'h7) begin
              rx_st_r <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (rx_sample) begin
            rx_done_r <= 1'b1; // [RL2]
            rx_st_r   <= S_IDLE;
          end
        end
        default: begin
          rx_st_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> verif/usdb_assertions.sv
// Purpose: Port checks for the shadow buffer UART core.
// Assumes: Register places from the shared constants header.
// Notes:   Follows control and mask writes to know the mode.
`include "usdb_consts.vh"
module usdb_assertions #(
  parameter        FIFO_AW  = 4,
  parameter [15:0] BAUD_DIV = 16'h0010
) (
  // Clock and reset
  input wire        ref_clk,
  input wire        nrst,
  // Register port
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire        wr_stb,
  input wire        rd_stb,
  input wire [31:0] rdata_r,
  // Pins
  input wire        sin,
  input wire        sir_in,
  input wire        sout,
  input wire        sir_out_n,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  reg  [1:0] ctrl_r;
  reg  [2:0] mask_r;
  wire       shadow;
  wire       mapped;
  ////////////////////////////////////////
  // Decode of the places that answer
  assign shadow = addr >= `USDB_ADDR_SH_FIRST && addr <= `USDB_ADDR_SH_LAST;
  assign mapped = shadow || addr == `USDB_ADDR_CTRL || addr == `USDB_ADDR_LSR
                  || addr == `USDB_ADDR_ISTAT || addr == `USDB_ADDR_IMASK;
  // Copies of the mode and mask registers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= 2'h0;
      mask_r <= 3'h0;
    end else if (wr_stb) begin
      if (addr == `USDB_ADDR_CTRL) ctrl_r <= wdata[1:0];
      if (addr == `USDB_ADDR_IMASK) mask_r <= wdata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_rdata_idle: assert property (!rd_stb |=> rdata_r == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_shadow_upper: assert property (rd_stb && shadow |=> rdata_r[31:8] == 24'h0)
    else $error("shadow read upper bits not zero");
  chk_unmapped_zero: assert property (rd_stb && !mapped |=> rdata_r == 32'h0)
    else $error("unmapped read not zero");
  chk_sout_ir_high: assert property (ctrl_r[1] |-> sout)
    else $error("serial output moved in infrared mode");
  chk_sout_width: assert property ($changed(sout) |=> $stable(sout))
    else $error("serial output bit shorter than two clocks");
  chk_irq_masked: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq)
    else $error("interrupt high with all sources masked");
  chk_tx_holding_empty_flag_write: assert property (wr_stb && shadow && !ctrl_r[0] ##1
    rd_stb && addr == `USDB_ADDR_LSR |=> !rdata_r[5])
    else $error("holding empty flag still set after a write");
  chk_mask_read: assert property (rd_stb && addr == `USDB_ADDR_IMASK
    |=> rdata_r == {29'h0, $past(mask_r)})
    else $error("mask read back differs");
endmodule
bind usdb_core usdb_assertions #(.FIFO_AW(FIFO_AW), .BAUD_DIV(BAUD_DIV)) u_usdb_assertions (
  .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata_r(rdata_r), .sin(sin), .sir_in(sir_in), .sout(sout),
  .sir_out_n(sir_out_n), .irq(irq)
);

// >>> verif/usdb_peer.sv
// Purpose: Serial peer on the far side of the shadow buffer UART.
// Assumes: 8 data bits, no parity, one stop, BIT clocks a bit.
// Notes:   An infrared zero is a high pulse of BIT-1 clocks.
module usdb_peer #(
  parameter int BIT = 4
) (
  // Clock
  input  wire logic ref_clk,
  // Lines toward the block
  output logic      sin,
  output logic      sir_in,
  // Lines from the block
  input  wire logic sout,
  input  wire logic sir_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rxq[$];
  int         ir_pulses = 0;
  ////////////////////////////////////////
  // Idle levels
  initial begin
    sin = 1'b1;
    sir_in = 1'b0;
  end
  // Send one frame, start bit, data LSB first, stop bit
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      sin <= ir | f[i];
      sir_in <= ir & ~f[i];
      repeat (BIT - 1) @(posedge ref_clk);
      sir_in <= 1'b0;
    end
  endtask
  // Decode frames on the serial output at mid bit
  initial forever begin : rx
    logic [7:0] b;
    @(negedge sout);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge ref_clk);
      b[i] = sout;
    end
    repeat (BIT) @(posedge ref_clk);
    rxq.push_back(b);
  end
  // Count infrared pulses
  always @(negedge sir_out_n) ir_pulses++;
endmodule

// >>> verif/test_uart_shadow_data_buffer.sv
// Purpose: Self checking bench for the shadow buffer UART core.
// Assumes: BAUD_DIV 4 and FIFO_AW 2, so each FIFO holds four bytes.
// Notes:   A monitor takes read data in the cycle after the strobe.
`include "usdb_consts.vh"
module test_uart_shadow_data_buffer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        rd_q = 1'b0;
  logic [31:0] v;
  logic [31:0] rdq[$];
  int          n_fail = 0;
  int          n_compared = 0;
  wire  [31:0] rdata_r;
  wire         sin, sir_in, sout, sir_out_n, irq;
  ////////////////////////////////////////
  // Clock, design and peer
  always #50 ref_clk = ~ref_clk;
  usdb_core #(.FIFO_AW(2), .BAUD_DIV(16'h0004)) u_usdb_core (
    .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_r(rdata_r), .sin(sin), .sir_in(sir_in), .sout(sout),
    .sir_out_n(sir_out_n), .irq(irq));
  usdb_peer #(.BIT(4)) u_usdb_peer (.ref_clk(ref_clk), .sin(sin), .sir_in(sir_in),
    .sout(sout), .sir_out_n(sir_out_n));
  // Read data monitor
  always @(posedge ref_clk) begin
    if (rd_q) rdq.push_back(rdata_r);
    rd_q <= rd_stb;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One strobe cycle; calls may follow each other with no gap
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    wr_stb <= w;
    rd_stb <= ~w;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic idle();
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    idle();
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    idle();
    chk(rdq.pop_front(), exp);
  endtask
  // Read a register until one bit sets, within a bounded number of reads
  task automatic poll(input logic [31:0] a, input int b);
    v = 32'h0;
    for (int i = 0; i < 100 && v[b] !== 1'b1; i++) begin
      acc(1'b0, a, 32'h0);
      idle();
      v = rdq.pop_front();
    end
    chk({31'h0, v[b]}, 32'h1);
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 3000 && u_usdb_peer.rxq.size() < n; i++) @(posedge ref_clk);
    chk(u_usdb_peer.rxq.size(), n);
  endtask
  ////////////////////////////////////////
  // Reset values and an unmapped place
  task automatic t_reset();
    rd_chk(`USDB_ADDR_SH_9, 32'h0);
    rd_chk(`USDB_ADDR_SH_10, 32'h0);
    rd_chk(`USDB_ADDR_LSR, 32'h60);
    rd_chk(32'h50001100, 32'h0);
    @(negedge ref_clk);
    chk({29'h0, sout, sir_out_n, irq}, 32'h6);
    @(posedge ref_clk);
  endtask
  // One byte, interrupt masked then unmasked
  task automatic t_rx_basic();
    u_usdb_peer.send(8'hA5, 1'b0);
    poll(`USDB_ADDR_LSR, 0);
    chk({31'h0, irq}, 32'h0);
    wr(`USDB_ADDR_IMASK, 32'h1);
    rd_chk(`USDB_ADDR_IMASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd_chk(`USDB_ADDR_ISTAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd_chk(`USDB_ADDR_SH_9, 32'hA5);
    rd_chk(`USDB_ADDR_LSR, 32'h60);
  endtask
  // Two bytes with no read between, FIFOs off
  task automatic t_ov_nofifo();
    u_usdb_peer.send(8'h11, 1'b0);
    poll(`USDB_ADDR_ISTAT, 0);
    u_usdb_peer.send(8'h22, 1'b0);
    poll(`USDB_ADDR_ISTAT, 1);
    rd_chk(`USDB_ADDR_LSR, 32'h63);
    rd_chk(`USDB_ADDR_SH_LAST, 32'h22);
    rd_chk(`USDB_ADDR_LSR, 32'h60);
  endtask
  // One byte on the infrared input
  task automatic t_ir_rx();
    wr(`USDB_ADDR_CTRL, 32'h2);
    u_usdb_peer.send(8'h3C, 1'b1);
    poll(`USDB_ADDR_ISTAT, 0);
    rd_chk(`USDB_ADDR_SH_FIRST, 32'h3C);
  endtask
  // Five bytes into a four deep receive FIFO
  task automatic t_rx_fifo();
    wr(`USDB_ADDR_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) u_usdb_peer.send(8'h10 + 8'(i), 1'b0);
    poll(`USDB_ADDR_ISTAT, 1);
    for (int i = 0; i < 4; i++) rd_chk(`USDB_ADDR_SH_FIRST + 4 * i, 32'h10 + i);
    rd_chk(`USDB_ADDR_LSR, 32'h62);
  endtask
  // Seven back to back writes into a four deep transmit FIFO
  task automatic t_tx_fifo();
    u_usdb_peer.rxq.delete();
    rd_chk(`USDB_ADDR_LSR, 32'h60);
    for (int i = 0; i < 7; i++) acc(1'b1, `USDB_ADDR_SH_FIRST + 4 * i, 32'h40 + i);
    idle();
    wait_rx(5);
    poll(`USDB_ADDR_LSR, 6);
    chk(u_usdb_peer.rxq.size(), 32'h5);
    for (int i = 0; i < 5; i++) chk(u_usdb_peer.rxq[i], 32'h40 + i);
  endtask
  // Back to back writes with FIFOs off, empty flag read between
  task automatic t_tx_nofifo();
    wr(`USDB_ADDR_CTRL, 32'h0);
    u_usdb_peer.rxq.delete();
    rd_chk(`USDB_ADDR_LSR, 32'h60);
    acc(1'b1, `USDB_ADDR_SH_9, 32'h155);
    acc(1'b0, `USDB_ADDR_LSR, 32'h0);
    acc(1'b1, `USDB_ADDR_SH_10, 32'h12);
    acc(1'b1, `USDB_ADDR_SH_10, 32'h34);
    idle();
    chk(rdq.pop_front() & 32'h20, 32'h0);
    wait_rx(2);
    poll(`USDB_ADDR_LSR, 6);
    chk(u_usdb_peer.rxq.size(), 32'h2);
    chk(u_usdb_peer.rxq[0], 32'h55);
    chk(u_usdb_peer.rxq[1], 32'h34);
  endtask
  // Infrared transmit: pulses only, serial output held high
  task automatic t_ir_tx();
    int p;
    wr(`USDB_ADDR_CTRL, 32'h2);
    u_usdb_peer.rxq.delete();
    p = u_usdb_peer.ir_pulses;
    wr(`USDB_ADDR_SH_9, 32'h0F);
    poll(`USDB_ADDR_LSR, 6);
    chk(u_usdb_peer.ir_pulses - p, 32'h5);
    chk(u_usdb_peer.rxq.size(), 32'h0);
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Reset for six cycles, then the scenarios
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_rx_basic();
    t_ov_nofifo();
    t_ir_rx();
    t_rx_fifo();
    t_tx_fifo();
    t_tx_nofifo();
    t_ir_tx();
    end_of_test();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
endmodule
